// ==== logic/uoic_config.sv ====
// user offset and interrupt configuration register bank, apb slave
// assumes apb master on clock; sensor samples and events arrive on clock
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

module uoic_config
    import uoic_pkg::*;
#(
    parameter int AXES = 3
)
(
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    // sample path, micro-g, x in [0], y in [1], z in [2]
    input  wire uoic_pkg::uoic_corr_t      accel_in [AXES],
    input  wire logic                      sample_valid,
    output uoic_pkg::uoic_corr_t           accel_output [AXES],
    output uoic_pkg::uoic_corr_t           accel_wakeup [AXES],
    // interrupt sources
    input  wire logic                      data_ready_event,
    input  wire logic                      data_ready_clear,
    input  wire logic                      first_pin_events,
    input  wire logic                      second_pin_events,
    output logic                           first_interrupt_pin,
    output logic                           second_interrupt_pin,
    // filter steering
    output logic                           highpass_reference_enable,
    output logic                           orientation_source_select,
    output logic                           filter_path_select,
    output logic                           irq
);
    import uoic_pkg::*;

    logic         [7:0] offset_reg [AXES];
    logic         [7:0] ctrl_reg;
    logic         [7:0] filter_reg;
    logic [`UOIC_IRQ_W-1:0] irq_status_reg;
    logic [`UOIC_IRQ_W-1:0] irq_mask_reg;
    logic         [31:0] prdata_reg;
    logic                pslverr_reg;
    logic                drdy_level_reg;
    logic                drdy_pulse_reg;
    logic                first_pin_reg;
    logic                second_pin_reg;
    logic                access;
    logic                wr;
    logic                addr_ok;
    logic [`UOIC_IRQ_W-1:0] irq_set;
    logic                drdy_sig;
    uoic_corr_t          corrected [AXES];

    // ------------------------------------------------------------------
    // apb decode; zero wait states
    // ------------------------------------------------------------------
    assign access  = psel & penable;
    assign wr      = access & pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    always_comb
    begin
        case (paddr)
            `UOIC_ADDR_X_OFS, `UOIC_ADDR_Y_OFS, `UOIC_ADDR_Z_OFS,
            `UOIC_ADDR_CTRL, `UOIC_ADDR_IRQ_STATUS, `UOIC_ADDR_IRQ_MASK,
            `UOIC_ADDR_FILTER:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // offset words, one per axis
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < AXES; g++)
        begin : g_axis
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    offset_reg[g] <= `UOIC_RST_OFS;
                else if (wr && paddr == `UOIC_ADDR_X_OFS + 12'(4 * g))
                    offset_reg[g] <= pwdata[7:0];
            end

            // one shared datapath serves output and wakeup copies
            uoic_offset_apply u_apply
            (
                .clock        (clock),
                .sys_rst      (sys_rst),
                .accel_in     (accel_in[g]),
                .offset_word  (offset_reg[g]),
                .weight_heavy (ctrl_reg[`UOIC_BIT_OFS_WEIGHT]),
                .apply        (1'b1),
                .accel_out    (corrected[g])
            );

            // raw copy delayed to line up with the corrected one
            uoic_corr_t raw_reg;
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    raw_reg <= 32'h00000000;
                else
                    raw_reg <= accel_in[g];
            end

            assign accel_output[g] = ctrl_reg[`UOIC_BIT_OFS_OUT] ? corrected[g] : raw_reg;
            // wakeup sees the offset under either enable
            assign accel_wakeup[g] =
                (ctrl_reg[`UOIC_BIT_OFS_WU] | ctrl_reg[`UOIC_BIT_OFS_OUT]) ?
                corrected[g] : raw_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // control and filter registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            ctrl_reg <= `UOIC_RST_CTRL;
        else if (wr && paddr == `UOIC_ADDR_CTRL)
            ctrl_reg <= pwdata[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            filter_reg <= `UOIC_RST_FILTER;
        else if (wr && paddr == `UOIC_ADDR_FILTER)
            filter_reg <= pwdata[7:0];
    end

    assign highpass_reference_enable = ctrl_reg[`UOIC_BIT_HP_REF];
    assign orientation_source_select = ctrl_reg[`UOIC_BIT_ORIENT_SRC];
    assign filter_path_select        = filter_reg[`UOIC_BIT_FILTER_PATH];

    // ------------------------------------------------------------------
    // data ready signalling
    // ------------------------------------------------------------------
    // latched level holds until the consumer clears it; new event wins
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            drdy_level_reg <= 1'b0;
        else if (data_ready_event)
            drdy_level_reg <= 1'b1;
        else if (data_ready_clear)
            drdy_level_reg <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            drdy_pulse_reg <= 1'b0;
        else
            drdy_pulse_reg <= data_ready_event;
    end

    assign drdy_sig = ctrl_reg[`UOIC_BIT_DRDY_PULSE] ? drdy_pulse_reg : drdy_level_reg;

    // ------------------------------------------------------------------
    // interrupt pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            first_pin_reg  <= 1'b0;
            second_pin_reg <= 1'b0;
        end
        else if (!ctrl_reg[`UOIC_BIT_IRQ_ENABLE])
        begin
            first_pin_reg  <= 1'b0;
            second_pin_reg <= 1'b0;
        end
        else if (ctrl_reg[`UOIC_BIT_PIN_MERGE])
        begin
            first_pin_reg  <= first_pin_events | drdy_sig | second_pin_events;
            second_pin_reg <= second_pin_events;
        end
        else
        begin
            first_pin_reg  <= first_pin_events | drdy_sig;
            second_pin_reg <= second_pin_events;
        end
    end

    assign first_interrupt_pin  = first_pin_reg;
    assign second_interrupt_pin = second_pin_reg;

    // ------------------------------------------------------------------
    // sticky interrupt status, write one to clear, set wins
    // ------------------------------------------------------------------
    // conflict flags offset-on-output while the highpass path is chosen
    assign irq_set[`UOIC_IRQ_DRDY]         = data_ready_event;
    assign irq_set[`UOIC_IRQ_EVENT]        = first_pin_events | second_pin_events;
    assign irq_set[`UOIC_IRQ_OFS_CONFLICT] = sample_valid &
        ctrl_reg[`UOIC_BIT_OFS_OUT] & filter_reg[`UOIC_BIT_FILTER_PATH];

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_status_reg <= '0;
        else if (wr && paddr == `UOIC_ADDR_IRQ_STATUS)
            irq_status_reg <= (irq_status_reg & ~pwdata[`UOIC_IRQ_W-1:0]) | irq_set;
        else
            irq_status_reg <= irq_status_reg | irq_set;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_mask_reg <= '0;
        else if (wr && paddr == `UOIC_ADDR_IRQ_MASK)
            irq_mask_reg <= pwdata[`UOIC_IRQ_W-1:0];
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ------------------------------------------------------------------
    // read data and error response
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_reg <= !addr_ok;
            case (paddr)
                `UOIC_ADDR_X_OFS:      prdata_reg <= {24'h000000, offset_reg[0]};
                `UOIC_ADDR_Y_OFS:      prdata_reg <= {24'h000000, offset_reg[1]};
                `UOIC_ADDR_Z_OFS:      prdata_reg <= {24'h000000, offset_reg[AXES-1]};
                `UOIC_ADDR_CTRL:       prdata_reg <= {24'h000000, ctrl_reg};
                `UOIC_ADDR_IRQ_STATUS: prdata_reg <= {28'h0000000, irq_status_reg};
                `UOIC_ADDR_IRQ_MASK:   prdata_reg <= {28'h0000000, irq_mask_reg};
                `UOIC_ADDR_FILTER:     prdata_reg <= {24'h000000, filter_reg};
                default:               prdata_reg <= 32'h00000000;
            endcase
        end
    end
endmodule : uoic_config

// ==== logic/uoic_defs.svh ====
// register offsets, field positions, reset values and scaling constants
// for the user offset and interrupt configuration block
// assumes inclusion by bare name from the package file
`ifndef UOIC_DEFS_SVH
`define UOIC_DEFS_SVH

// ----------------------------------------------------------------------
// register byte addresses (printed indices times four)
// ----------------------------------------------------------------------
`define UOIC_IDX_X_OFS        8'h3C
`define UOIC_IDX_Y_OFS        8'h3D
`define UOIC_IDX_Z_OFS        8'h3E
`define UOIC_IDX_CTRL         8'h3F
`define UOIC_ADDR_X_OFS       12'h0F0
`define UOIC_ADDR_Y_OFS       12'h0F4
`define UOIC_ADDR_Z_OFS       12'h0F8
`define UOIC_ADDR_CTRL        12'h0FC
`define UOIC_ADDR_IRQ_STATUS  12'h100
`define UOIC_ADDR_IRQ_MASK    12'h104
`define UOIC_ADDR_FILTER      12'h108

// ----------------------------------------------------------------------
// control register fields, and the filter register path bit
// ----------------------------------------------------------------------
`define UOIC_BIT_DRDY_PULSE   7
`define UOIC_BIT_PIN_MERGE    6
`define UOIC_BIT_IRQ_ENABLE   5
`define UOIC_BIT_OFS_OUT      4
`define UOIC_BIT_OFS_WU       3
`define UOIC_BIT_OFS_WEIGHT   2
`define UOIC_BIT_HP_REF       1
`define UOIC_BIT_ORIENT_SRC   0
`define UOIC_BIT_FILTER_PATH  0

// ----------------------------------------------------------------------
// irq status bits
// ----------------------------------------------------------------------
`define UOIC_IRQ_DRDY         0
`define UOIC_IRQ_EVENT        1
`define UOIC_IRQ_OFS_CONFLICT 2
`define UOIC_IRQ_W            3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UOIC_RST_OFS          8'h00
`define UOIC_RST_CTRL         8'h00
`define UOIC_RST_FILTER       8'h00

// ----------------------------------------------------------------------
// offset weight: micro-g per lsb, light 977 ug, heavy 15.6 mg
// ----------------------------------------------------------------------
`define UOIC_WEIGHT_LIGHT_UG  16'd977
`define UOIC_WEIGHT_HEAVY_UG  16'd15600

`endif

// ==== logic/uoic_offset_apply.sv ====
// one axis of user offset correction, in micro-g units
// assumes acceleration samples already scaled to micro-g
`timescale 1ns/1ps

module uoic_offset_apply
    import uoic_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire uoic_pkg::uoic_corr_t   accel_in,
    input  wire uoic_pkg::uoic_offset_t offset_word,
    input  wire logic              weight_heavy,
    input  wire logic              apply,
    output uoic_pkg::uoic_corr_t   accel_out
);
    import uoic_pkg::*;

    uoic_corr_t scaled;
    uoic_corr_t accel_out_reg;

    // ------------------------------------------------------------------
    // weight the signed offset word
    // ------------------------------------------------------------------
    always_comb
    begin
        if (weight_heavy)
            scaled = 32'(offset_word) * $signed({16'h0000, `UOIC_WEIGHT_HEAVY_UG});
        else
            scaled = 32'(offset_word) * $signed({16'h0000, `UOIC_WEIGHT_LIGHT_UG});
    end

    // offset is subtracted: it describes the error present in the sample
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            accel_out_reg <= 32'h00000000;
        else if (apply)
            accel_out_reg <= accel_in - scaled;
        else
            accel_out_reg <= accel_in;
    end

    assign accel_out = accel_out_reg;
endmodule : uoic_offset_apply

// ==== logic/uoic_pkg.sv ====
// types shared by the user offset and interrupt configuration block
// assumes uoic_defs.svh on the include path
`include "uoic_defs.svh"

package uoic_pkg;
    typedef logic signed [7:0]  uoic_offset_t;
    typedef logic signed [15:0] uoic_accel_t;
    typedef logic signed [31:0] uoic_corr_t;
    typedef enum logic {UOIC_DRDY_LATCHED, UOIC_DATA_READY_PULSE_SELECT} uoic_drdy_mode_t;
endpackage : uoic_pkg

// ==== tb/tb.sv ====
// self-checking bench for the user offset and interrupt configuration block
// assumes the checker is bound in by its own file; apb is driven from here
`timescale 1ns/1ps

module tb;
    import uoic_pkg::*;
    logic         clock = 1'b0;
    logic         sys_rst = 1'b1;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic         sample_valid = 1'b1;
    logic         data_ready_event = 1'b0;
    logic         data_ready_clear = 1'b0;
    logic         first_pin_events = 1'b0;
    logic         second_pin_events = 1'b0;
    uoic_corr_t   accel_in [3] = '{32'sh0001_0000, 32'shFFFF_0000, 32'sh0000_1234};
    uoic_corr_t   accel_output [3];
    uoic_corr_t   accel_wakeup [3];
    uoic_offset_t ofs [3] = '{8'sh7F, 8'sh80, 8'shFE};
    logic [7:0]   modes [5] = '{8'h12, 8'h15, 8'h0A, 8'h0D, 8'h00};
    logic [7:0]   md;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, err, irq, filter_path_select;
    logic         first_interrupt_pin, second_interrupt_pin;
    logic         highpass_reference_enable, orientation_source_select;
    int           errors = 0;
    int           num_checks = 0;
    int           cnt;

    uoic_config #(.AXES(3)) dut
    (
        .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .accel_in, .sample_valid, .accel_output, .accel_wakeup, .data_ready_event,
        .data_ready_clear, .first_pin_events, .second_pin_events, .first_interrupt_pin,
        .second_interrupt_pin, .highpass_reference_enable, .orientation_source_select,
        .filter_path_select, .irq
    );

    always #50 clock = ~clock;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    // weights in micro-g: 0x3D1 is 977, 0x3CF0 is 15600
    function automatic uoic_corr_t ex(int i, logic on);
        return on ? accel_in[i] - ofs[i] * (md[2] ? 32'sh3CF0 : 32'sh3D1) : accel_in[i];
    endfunction : ex

    task automatic complete_run();
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stalled wait
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wait_n(input int c);
        repeat (c) @(posedge clock);
        @(negedge clock);
    endtask : wait_n

    task automatic strobe(input logic clr);
        @(posedge clock);
        if (clr)
            data_ready_clear <= 1'b1;
        else
            data_ready_event <= 1'b1;
        @(posedge clock);
        data_ready_clear <= 1'b0;
        data_ready_event <= 1'b0;
    endtask : strobe

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        // a hung handshake would otherwise stall the run forever
        #(3000 * 100);
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        // eight words from the first offset: the last one is unmapped
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b0, 12'h0F0 + 12'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
            chk("slverr", 32'(i == 7), 32'(err));
        end
        for (int i = 0; i < 3; i++)
            xfer(1'b1, 12'h0F0 + 12'(4 * i), {24'hFFFFFF, ofs[i]});
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b0, 12'h0F0 + 12'(4 * i), 32'h0);
            chk("offset word", {24'h0, ofs[i]}, rd);
        end
        xfer(1'b1, 12'h108, 32'h1);
        wait_n(1);
        chk("filter path", 32'h1, 32'(filter_path_select));
        xfer(1'b1, 12'h108, 32'h0);
        foreach (modes[m])
        begin
            md = modes[m];
            xfer(1'b1, 12'h0FC, {24'h0, md});
            wait_n(2);
            for (int i = 0; i < 3; i++)
            begin
                chk("output", ex(i, md[4]), accel_output[i]);
                chk("wakeup", ex(i, md[4] | md[3]), accel_wakeup[i]);
            end
            chk("hp ref", 32'(md[1]), 32'(highpass_reference_enable));
            chk("orient", 32'(md[0]), 32'(orientation_source_select));
        end
        @(posedge clock);
        first_pin_events <= 1'b1;
        second_pin_events <= 1'b1;
        data_ready_event <= 1'b1;
        wait_n(4);
        chk("pin1 off", 32'h0, 32'(first_interrupt_pin));
        chk("pin2 off", 32'h0, 32'(second_interrupt_pin));
        @(posedge clock);
        first_pin_events <= 1'b0;
        data_ready_event <= 1'b0;
        strobe(1'b1);
        xfer(1'b1, 12'h0FC, 32'h20);
        wait_n(4);
        chk("pin2 on", 32'h1, 32'(second_interrupt_pin));
        chk("pin1 unmerged", 32'h0, 32'(first_interrupt_pin));
        xfer(1'b1, 12'h0FC, 32'h60);
        wait_n(4);
        chk("pin1 merged", 32'h1, 32'(first_interrupt_pin));
        @(posedge clock);
        second_pin_events <= 1'b0;
        xfer(1'b1, 12'h0FC, 32'h20);
        strobe(1'b0);
        wait_n(6);
        chk("ready latched", 32'h1, 32'(first_interrupt_pin));
        strobe(1'b1);
        wait_n(4);
        chk("ready cleared", 32'h0, 32'(first_interrupt_pin));
        xfer(1'b1, 12'h0FC, 32'hA0);
        strobe(1'b0);
        cnt = 0;
        repeat (8)
        begin
            @(negedge clock);
            if (first_interrupt_pin === 1'b1)
                cnt++;
        end
        chk("ready pulse", 32'h1, 32'(cnt));
        xfer(1'b0, 12'h100, 32'h0);
        chk("event status", 32'h1, 32'(rd[1]));
        xfer(1'b1, 12'h100, 32'hF);
        strobe(1'b0);
        wait_n(1);
        chk("irq masked", 32'h0, 32'(irq));
        xfer(1'b0, 12'h100, 32'h0);
        chk("ready status", 32'h1, 32'(rd[0]));
        xfer(1'b1, 12'h104, 32'h1);
        wait_n(1);
        chk("irq unmasked", 32'h1, 32'(irq));
        xfer(1'b1, 12'h100, 32'h1);
        wait_n(1);
        chk("irq cleared", 32'h0, 32'(irq));
        // offset on output while the highpass path is still chosen is flagged
        xfer(1'b1, 12'h108, 32'h1);
        xfer(1'b1, 12'h0FC, 32'h10);
        xfer(1'b0, 12'h100, 32'h0);
        chk("ofs conflict", 32'h1, 32'(rd[2]));
        complete_run();
    end
endmodule : tb

// ==== tb/uoic_config_checker.sv ====
// concurrent checks on the user offset and interrupt configuration block
// assumes binding onto uoic_config; register shadows are rebuilt from apb writes
`timescale 1ns/1ps

module uoic_config_checker
    import uoic_pkg::*;
#(
    parameter int AXES = 3
)
(
    input logic                 clock,
    input logic                 sys_rst,
    input logic                 psel,
    input logic                 penable,
    input logic                 pwrite,
    input logic [11:0]          paddr,
    input logic [31:0]          pwdata,
    input logic [31:0]          prdata,
    input uoic_pkg::uoic_corr_t accel_in [AXES],
    input uoic_pkg::uoic_corr_t accel_output [AXES],
    input uoic_pkg::uoic_corr_t accel_wakeup [AXES],
    input logic                 second_pin_events,
    input logic                 first_interrupt_pin,
    input logic                 second_interrupt_pin,
    input logic                 highpass_reference_enable,
    input logic                 orientation_source_select
);
    import uoic_pkg::*;

    // ------------------------------------------------------------------
    // shadows
    // ------------------------------------------------------------------
    logic [7:0]   ctrl_reg;
    uoic_offset_t zofs_reg;
    uoic_corr_t   zexp;
    logic         wr;

    assign wr = psel && penable && pwrite;
    // z only: the three axes share one datapath shape
    assign zexp = accel_in[2] - zofs_reg * (ctrl_reg[2] ? 32'sh3CF0 : 32'sh3D1);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            ctrl_reg <= 8'h00;
        else if (wr && paddr == 12'h0FC)
            ctrl_reg <= pwdata[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            zofs_reg <= 8'sh00;
        else if (wr && paddr == 12'h0F8)
            zofs_reg <= pwdata[7:0];
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_merge_held;
        (ctrl_reg[5] && ctrl_reg[6]) [*3];
    endsequence
    sequence s_gate_off;
        (!ctrl_reg[5]) [*4];
    endsequence

    // the output mux follows the live control bits, the datapath lags one cycle
    a_offset_on_out: assert property (ctrl_reg[4] && !$past(sys_rst) |->
        accel_output[2] == $past(zexp) && accel_wakeup[2] == $past(zexp))
        else $error("output offset correction wrong");
    a_offset_wu_only: assert property (ctrl_reg[4:3] == 2'b01 && !$past(sys_rst) |->
        accel_output[2] == $past(accel_in[2]) && accel_wakeup[2] == $past(zexp))
        else $error("wakeup-only offset wrong");
    a_wakeup_raw: assert property (ctrl_reg[4:3] == 2'b00 && !$past(sys_rst) |->
        accel_wakeup[2] == $past(accel_in[2]))
        else $error("wakeup data corrected while off");
    a_hp_ref: assert property (highpass_reference_enable == ctrl_reg[1])
        else $error("highpass reference mode mismatch");
    a_orient_src: assert property (orientation_source_select == ctrl_reg[0])
        else $error("orientation source mismatch");
    a_gate_off: assert property (s_gate_off |-> !first_interrupt_pin && !second_interrupt_pin)
        else $error("interrupt pin active while disabled");
    a_pin_merge: assert property (s_merge_held ##0 $past(second_pin_events)
        |-> first_interrupt_pin)
        else $error("merged event missing on first pin");
    a_read_zofs: assert property (psel && penable && !pwrite && paddr == 12'h0F8
        |-> prdata == {24'h000000, zofs_reg})
        else $error("z offset readback wrong");
endmodule : uoic_config_checker

bind uoic_config uoic_config_checker #(.AXES(AXES)) u_checker
(
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .accel_in,
    .accel_output, .accel_wakeup, .second_pin_events, .first_interrupt_pin,
    .second_interrupt_pin, .highpass_reference_enable, .orientation_source_select
);
